// ---- verilog/des_pkg.sv ----
// Purpose: shared constants for the datacomm error supervisor
// Assumes: 10 MHz clock, avalon-mm register bus, word-aligned registers
// Notes: register numbers are indices; byte address is index times four
package des_pkg;
    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [5:0] REG_RESET = 6'h00;
    localparam logic [5:0] REG_CONNECT = 6'h0C;
    localparam logic [5:0] REG_CONN_LIMIT = 6'h10;
    localparam logic [5:0] REG_IDLE_LIMIT = 6'h11;
    localparam logic [5:0] REG_CARRIER_LIMIT = 6'h12;
    localparam logic [5:0] REG_TX_LIMIT = 6'h13;
    localparam logic [5:0] REG_TX_SPEED = 6'h14;
    localparam logic [5:0] REG_DUPLEX = 6'h17;
    localparam logic [5:0] REG_CHAR_LEN = 6'h22;
    localparam logic [5:0] REG_PARITY = 6'h24;
    localparam logic [5:0] REG_ERR_CODE = 6'h28;
    localparam logic [5:0] REG_IRQ_STATUS = 6'h29;
    localparam logic [5:0] REG_IRQ_MASK = 6'h2A;
    localparam logic [5:0] REG_CLEAR = 6'h2B;
    localparam logic [5:0] REG_LAST = 6'h2B;
    // ------------------------------------------------------------------
    // error codes
    // ------------------------------------------------------------------
    localparam logic [9:0] ERR_NONE = 10'h000;
    localparam logic [9:0] ERR_SELF_TEST = 10'd306;
    localparam logic [9:0] ERR_RX_OVERRUN = 10'd313;
    localparam logic [9:0] ERR_HOST_OVERFLOW = 10'd314;
    localparam logic [9:0] ERR_NO_TX_CLOCK = 10'd315;
    localparam logic [9:0] ERR_CTS_TIMEOUT = 10'd316;
    localparam logic [9:0] ERR_LOST_CARRIER = 10'd317;
    localparam logic [9:0] ERR_NO_ACTIVITY = 10'd318;
    localparam logic [9:0] ERR_NO_CONNECT = 10'd319;
    localparam logic [9:0] ERR_BAD_FORMAT = 10'd325;
    localparam logic [9:0] ERR_BAD_REG = 10'd326;
    localparam logic [9:0] ERR_BAD_VALUE = 10'd327;
    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int BIT_SELF_TEST = 0;
    localparam int BIT_LINE_FAULT = 1;
    localparam int BIT_CONFIG = 2;
    localparam int IRQ_W = 3;
    // ------------------------------------------------------------------
    // line states and field values
    // ------------------------------------------------------------------
    localparam logic [7:0] LINE_IDLE = 8'h00;
    localparam logic [7:0] LINE_CONNECTING = 8'h01;
    localparam logic [7:0] LINE_CONNECTED = 8'h03;
    localparam logic [7:0] LINE_SUSPENDED = 8'h04;
    localparam logic [7:0] CHAR_LEN_8 = 8'h03;
    localparam logic [7:0] PAR_FORCE_ONE = 8'h03;
    localparam logic [7:0] PAR_FORCE_ZERO = 8'h04;
    localparam logic [7:0] PAR_MAX = 8'h04;
    localparam logic [7:0] CHAR_LEN_MAX = 8'h03;
    localparam logic [7:0] DUPLEX_MAX = 8'h03;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONN_LIMIT = 8'h19;
    localparam logic [7:0] RST_IDLE_LIMIT = 8'h00;
    localparam logic [7:0] RST_CARRIER_LIMIT = 8'h28;
    localparam logic [7:0] RST_TX_LIMIT = 8'h0A;
    localparam logic [7:0] RST_TX_SPEED = 8'h07;
    localparam logic [7:0] RST_DUPLEX = 8'h00;
    localparam logic [7:0] RST_CHAR_LEN = 8'h02;
    localparam logic [7:0] RST_PARITY = 8'h00;
    // ------------------------------------------------------------------
    // timing: limit unit lengths
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_10MS_US = 10_000;
    localparam int TICK_1S_US = 1_000_000;
    localparam int CYC_10MS = TICK_10MS_US / (1_000_000 / CLK_HZ * 0 + 1) / 1 * (CLK_HZ / 1_000_000);
    localparam int CYC_1S = TICK_1S_US * (CLK_HZ / 1_000_000);
endpackage

// ---- verilog/des_limit_timer.sv ----
// Purpose: one supervision timer counting ticks while a fault condition holds
// Assumes: tick is a one-cycle pulse in the same clock domain
// Notes: a limit of zero disables the timer
`timescale 1ns/1ps
module des_limit_timer
    import des_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    // result
    output logic expired
);
    logic [W-1:0] count;

    always_ff @(posedge clk) begin
        if (srst || !run || limit == '0) begin
            count <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (count + W'(1) >= limit) begin
                expired <= 1'b1;
            end
            count <= count + W'(1);
        end
    end
endmodule

// ---- verilog/des_supervisor.sv ----
// Purpose: error supervision and fault handling for a serial datacomm card
// Assumes: line-side pins are asynchronous, host reaches registers via avalon-mm
// Notes: one word per register, data in the low bits, unused bits read zero
`timescale 1ns/1ps

module des_supervisor
    import des_pkg::*;
#(
    parameter int CYC_LIMIT_UNIT = CYC_10MS,
    parameter int CYC_TX_UNIT = CYC_1S
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // line side, asynchronous
    input wire logic dsr,
    input wire logic dcd,
    input wire logic cts,
    input wire logic ext_tx_clk,
    // datapath events, same clock
    input wire logic self_test_fail,
    input wire logic serial_receiver_holding_buffer_overrun,
    input wire logic host_buffer_overflow,
    input wire logic tx_pending,
    input wire logic tx_activity,
    input wire logic rx_activity,
    // line control and interrupt
    output logic line_enable,
    output logic ext_clk_select,
    output logic irq
);
    typedef enum logic [3:0] {
        DES_IDLE = 4'b0001,
        DES_CONNECTING = 4'b0010,
        DES_CONNECTED = 4'b0100,
        DES_SUSPENDED = 4'b1000
    } des_line_e;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic ext_clk_prev;
    always_ff @(posedge clk) begin
        sync_a <= {ext_tx_clk, cts, dcd, dsr};
        sync_b <= sync_a;
        ext_clk_prev <= sync_b[3];
    end
    wire logic dsr_s = sync_b[0];
    wire logic dcd_s = sync_b[1];
    wire logic cts_s = sync_b[2];
    wire logic ext_edge = sync_b[3] & ~ext_clk_prev;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    des_line_e line_state;
    logic [7:0] conn_limit;
    logic [7:0] idle_limit;
    logic [7:0] carrier_limit;
    logic [7:0] tx_limit;
    logic [7:0] tx_speed;
    logic [7:0] duplex;
    logic [7:0] char_len;
    logic [7:0] parity;
    logic [9:0] err_code;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic st_done;

    function automatic logic reg_exists(input logic [5:0] idx);
        case (idx)
            REG_RESET, REG_CONNECT, REG_CONN_LIMIT, REG_IDLE_LIMIT,
            REG_CARRIER_LIMIT, REG_TX_LIMIT, REG_TX_SPEED, REG_DUPLEX,
            REG_CHAR_LEN, REG_PARITY, REG_ERR_CODE, REG_IRQ_STATUS,
            REG_IRQ_MASK, REG_CLEAR: reg_exists = 1'b1;
            default: reg_exists = 1'b0;
        endcase
    endfunction

    function automatic logic value_ok(input logic [5:0] idx, input logic [31:0] v);
        case (idx)
            REG_RESET, REG_CLEAR: value_ok = (v <= 32'h0000_0001);
            REG_CONNECT: value_ok = (v <= 32'h0000_0001);
            REG_CHAR_LEN: value_ok = (v <= 32'(CHAR_LEN_MAX));
            REG_PARITY: value_ok = (v <= 32'(PAR_MAX));
            REG_DUPLEX: value_ok = (v <= 32'(DUPLEX_MAX));
            REG_ERR_CODE, REG_IRQ_STATUS: value_ok = 1'b0;
            REG_IRQ_MASK: value_ok = (v < (32'h0000_0001 << IRQ_W));
            default: value_ok = (v <= 32'h0000_00FF);
        endcase
    endfunction

    function automatic logic forced_parity(input logic [7:0] p);
        forced_parity = (p == PAR_FORCE_ONE) || (p == PAR_FORCE_ZERO);
    endfunction

    // ------------------------------------------------------------------
    // bus decode: one wait cycle, answer on the second cycle
    // ------------------------------------------------------------------
    logic busy;
    wire logic [5:0] idx = avs_address[7:2];
    wire logic acc = (avs_read | avs_write) & busy;
    wire logic wr = avs_write & busy;
    wire logic exists = reg_exists(idx) && avs_address[1:0] == 2'b00;
    wire logic good = exists && value_ok(idx, avs_writedata);
    wire logic [7:0] wv = avs_writedata[7:0];
    wire logic bad_combo = (idx == REG_CHAR_LEN && wv == CHAR_LEN_8 && forced_parity(parity))
        || (idx == REG_PARITY && char_len == CHAR_LEN_8 && forced_parity(wv));
    wire logic do_wr = wr && good && !bad_combo;
    wire logic do_reset = do_wr && idx == REG_RESET && wv[0];
    wire logic do_clear = do_wr && idx == REG_CLEAR && wv[0];
    wire logic do_conn = do_wr && idx == REG_CONNECT && wv[0];
    wire logic rd_status = avs_read && !busy && exists && idx == REG_IRQ_STATUS;

    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= (avs_read | avs_write) & ~busy;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~busy);
        end
    end

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    logic [31:0] unit_cnt;
    logic [31:0] sec_cnt;
    wire logic tick_unit = unit_cnt == 32'(CYC_LIMIT_UNIT - 1);
    wire logic tick_sec = sec_cnt == 32'(CYC_TX_UNIT - 1);
    always_ff @(posedge clk) begin
        if (srst) begin
            unit_cnt <= 32'h0000_0000;
            sec_cnt <= 32'h0000_0000;
        end else begin
            unit_cnt <= tick_unit ? 32'h0000_0000 : unit_cnt + 32'h0000_0001;
            sec_cnt <= tick_sec ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
        end
    end

    wire logic full_dup = duplex[0];
    wire logic carrier_ok = dsr_s && (!full_dup || dcd_s);
    wire logic online = line_state == DES_CONNECTED;
    wire logic ext_mode = tx_speed == 8'h00;
    wire logic clk_block = tx_pending && ext_mode && !ext_edge;
    wire logic cts_block = tx_pending && !full_dup && !cts_s;
    logic exp_tx;
    logic exp_cts;
    logic exp_car;
    logic exp_idle;
    logic exp_conn;

    des_limit_timer #(.W(8)) u_tx_tmr (
        .clk(clk), .srst(srst | do_reset), .run(online && clk_block), .tick(tick_sec),
        .limit(tx_limit), .expired(exp_tx));
    des_limit_timer #(.W(8)) u_cts_tmr (
        .clk(clk), .srst(srst | do_reset), .run(online && cts_block), .tick(tick_sec),
        .limit(tx_limit), .expired(exp_cts));
    des_limit_timer #(.W(8)) u_car_tmr (
        .clk(clk), .srst(srst | do_reset), .run(online && !carrier_ok), .tick(tick_unit),
        .limit(carrier_limit), .expired(exp_car));
    des_limit_timer #(.W(8)) u_idle_tmr (
        .clk(clk), .srst(srst | do_reset),
        .run(online && !tx_activity && !rx_activity), .tick(tick_sec),
        .limit(idle_limit), .expired(exp_idle));
    des_limit_timer #(.W(8)) u_conn_tmr (
        .clk(clk), .srst(srst | do_reset),
        .run(line_state == DES_CONNECTING && !carrier_ok), .tick(tick_sec),
        .limit(conn_limit), .expired(exp_conn));

    // ------------------------------------------------------------------
    // fault selection, lowest code first
    // ------------------------------------------------------------------
    logic [9:0] line_err;
    always_comb begin
        line_err = ERR_NONE;
        if (line_state == DES_CONNECTING || online) begin
            if (serial_receiver_holding_buffer_overrun) begin
                line_err = ERR_RX_OVERRUN;
            end else if (host_buffer_overflow) begin
                line_err = ERR_HOST_OVERFLOW;
            end else if (exp_tx) begin
                line_err = ERR_NO_TX_CLOCK;
            end else if (exp_cts) begin
                line_err = ERR_CTS_TIMEOUT;
            end else if (exp_car) begin
                line_err = ERR_LOST_CARRIER;
            end else if (exp_idle) begin
                line_err = ERR_NO_ACTIVITY;
            end else if (exp_conn) begin
                line_err = ERR_NO_CONNECT;
            end
        end
    end
    wire logic line_fault = line_err != ERR_NONE;

    // bad register; bad value; bad format
    logic [9:0] cfg_err;
    always_comb begin
        cfg_err = ERR_NONE;
        if (acc && !exists) begin
            cfg_err = ERR_BAD_REG;
        end else if (wr && !good) begin
            cfg_err = ERR_BAD_VALUE;
        end else if (wr && bad_combo) begin
            cfg_err = ERR_BAD_FORMAT;
        end
    end

    // ------------------------------------------------------------------
    // line state machine
    // ------------------------------------------------------------------
    // suspend until clear or reset
    always_ff @(posedge clk) begin
        if (srst || do_reset) begin
            line_state <= DES_IDLE;
        end else begin
            case (line_state)
                DES_IDLE: begin
                    if (do_conn) begin
                        line_state <= DES_CONNECTING;
                    end
                end
                DES_CONNECTING: begin
                    if (line_fault) begin
                        line_state <= DES_SUSPENDED;
                    end else if (carrier_ok) begin
                        line_state <= DES_CONNECTED;
                    end
                end
                DES_CONNECTED: begin
                    if (line_fault) begin
                        line_state <= DES_SUSPENDED;
                    end
                end
                DES_SUSPENDED: begin
                    if (do_clear) begin
                        line_state <= DES_IDLE;
                    end
                end
                default: line_state <= DES_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            line_enable <= 1'b0;
            ext_clk_select <= 1'b0;
        end else begin
            line_enable <= (line_state == DES_CONNECTING || online) && !line_fault;
            ext_clk_select <= ext_mode;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst || do_reset) begin
            conn_limit <= RST_CONN_LIMIT;
            idle_limit <= RST_IDLE_LIMIT;
            carrier_limit <= RST_CARRIER_LIMIT;
            tx_limit <= RST_TX_LIMIT;
            tx_speed <= RST_TX_SPEED;
            duplex <= RST_DUPLEX;
            char_len <= RST_CHAR_LEN;
            parity <= RST_PARITY;
            irq_mask <= '0;
        end else if (do_wr) begin
            case (idx)
                REG_CONN_LIMIT: conn_limit <= wv;
                REG_IDLE_LIMIT: idle_limit <= wv;
                REG_CARRIER_LIMIT: carrier_limit <= wv;
                REG_TX_LIMIT: tx_limit <= wv;
                REG_TX_SPEED: tx_speed <= wv;
                REG_DUPLEX: duplex <= wv;
                REG_CHAR_LEN: char_len <= wv;
                REG_PARITY: parity <= wv;
                REG_IRQ_MASK: irq_mask <= wv[IRQ_W-1:0];
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // error code, sticky status, interrupt
    // ------------------------------------------------------------------
    // self-test result is caught one edge after reset release
    always_ff @(posedge clk) begin
        if (srst) begin
            st_done <= 1'b0;
        end else begin
            st_done <= 1'b1;
        end
    end
    wire logic st_err = !st_done && self_test_fail;

    logic [IRQ_W-1:0] events;
    always_comb begin
        events = '0;
        events[BIT_SELF_TEST] = st_err;
        events[BIT_LINE_FAULT] = line_fault;
        events[BIT_CONFIG] = cfg_err != ERR_NONE;
    end

    // self-test code; error number with interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            err_code <= ERR_NONE;
        end else if (st_err) begin
            err_code <= ERR_SELF_TEST;
        end else if (line_fault) begin
            err_code <= line_err;
        end else if (cfg_err != ERR_NONE) begin
            err_code <= cfg_err;
        end
    end

    // sticky events, set wins over read clear
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (rd_status ? '0 : irq_status) | events;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((rd_status ? '0 : irq_status) | events) & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [7:0] line_code;
    always_comb begin
        case (line_state)
            DES_CONNECTING: line_code = LINE_CONNECTING;
            DES_CONNECTED: line_code = LINE_CONNECTED;
            DES_SUSPENDED: line_code = LINE_SUSPENDED;
            default: line_code = LINE_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !busy) begin
            case (exists ? idx : 6'h3F)
                REG_CONNECT: avs_readdata <= {24'h00_0000, line_code};
                REG_CONN_LIMIT: avs_readdata <= {24'h00_0000, conn_limit};
                REG_IDLE_LIMIT: avs_readdata <= {24'h00_0000, idle_limit};
                REG_CARRIER_LIMIT: avs_readdata <= {24'h00_0000, carrier_limit};
                REG_TX_LIMIT: avs_readdata <= {24'h00_0000, tx_limit};
                REG_TX_SPEED: avs_readdata <= {24'h00_0000, tx_speed};
                REG_DUPLEX: avs_readdata <= {24'h00_0000, duplex};
                REG_CHAR_LEN: avs_readdata <= {24'h00_0000, char_len};
                REG_PARITY: avs_readdata <= {24'h00_0000, parity};
                REG_ERR_CODE: avs_readdata <= {22'h0_0000, err_code};
                REG_IRQ_STATUS: avs_readdata <= {{(32 - IRQ_W){1'b0}}, irq_status};
                REG_IRQ_MASK: avs_readdata <= {{(32 - IRQ_W){1'b0}}, irq_mask};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- test/des_supervisor_asserts.sv ----
// Purpose: port-level checks for the supervisor
// Assumes: one clock, srst synchronous
// Notes: access-related outputs may lag a request by a few cycles
`timescale 1ns/1ps
module des_supervisor_asserts
    import des_pkg::*;
(
    // clock, bus and events
    input wire logic clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic serial_receiver_holding_buffer_overrun,
    input wire logic host_buffer_overflow,
    // outputs watched
    input wire logic line_enable,
    input wire logic ext_clk_select,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // cycles since the last host access, saturating
    logic [1:0] since_acc;
    always_ff @(posedge clk) begin
        if (srst || avs_read || avs_write) begin
            since_acc <= 2'h0;
        end else if (since_acc != 2'h3) begin
            since_acc <= since_acc + 2'h1;
        end
    end
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_answer;
        (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_only_req;
        !avs_waitrequest |-> $past(avs_read || avs_write);
    endproperty
    a_only_req: assert property (p_only_req) else $error("answer unasked");
    property p_sel;
        $changed(ext_clk_select) |-> since_acc != 2'h3;
    endproperty
    a_sel: assert property (p_sel) else $error("clock select moved alone");
    property p_ovr;
        serial_receiver_holding_buffer_overrun && line_enable |-> ##[1:4] !line_enable;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun kept line");
    property p_hovf;
        host_buffer_overflow && line_enable |-> ##[1:4] !line_enable;
    endproperty
    a_hovf: assert property (p_hovf) else $error("overflow kept line");
    property p_held;
        $rose(line_enable) |-> since_acc != 2'h3;
    endproperty
    a_held: assert property (p_held) else $error("line came back alone");
    property p_irq;
        $fell(irq) |-> since_acc != 2'h3;
    endproperty
    a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule
bind des_supervisor des_supervisor_asserts des_supervisor_asserts_inst (.clk, .srst,
    .avs_read, .avs_write, .avs_waitrequest, .serial_receiver_holding_buffer_overrun,
    .host_buffer_overflow, .line_enable, .ext_clk_select, .irq);

// ---- test/des_line_model.sv ----
// Purpose: modem seen from the card's line pins
// Assumes: answers a raised line after three cycles when told to
// Notes: no external transmit clock is ever supplied
`timescale 1ns/1ps
module des_line_model (
    // control
    input wire logic clk,
    input wire logic line_enable,
    input wire logic answer,
    // modem pins
    output logic dsr,
    output logic dcd,
    output logic cts,
    output logic ext_tx_clk
);
    logic [2:0] dly = 3'h0;
    always_ff @(posedge clk) begin
        dly <= {dly[1:0], line_enable & answer};
    end
    assign dsr = dly[2];
    assign dcd = dly[2];
    assign cts = dly[2];
    assign ext_tx_clk = 1'b0;
endmodule

// ---- test/des_supervisor_bench.sv ----
// Purpose: self-checking bench for the supervisor
// Assumes: limit units shortened to 10 and 50 cycles
// Notes: reads are checked against a queue of expected words
`timescale 1ns/1ps
module des_supervisor_bench
    import des_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic stf = 1'b1;
    logic ovr = 1'b0;
    logic hovf = 1'b0;
    logic answer = 1'b1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, dsr, dcd, cts, ext_tx_clk, line_enable, ext_clk_select, irq;
    logic [31:0] expq[$];
    logic [31:0] lfsr = 32'h0000_c21d;
    int miscompares = 0;
    int checks_done = 0;
    logic [5:0] ri[6] = '{REG_CONN_LIMIT, REG_CARRIER_LIMIT, REG_TX_LIMIT, REG_TX_SPEED,
        REG_CHAR_LEN, REG_PARITY};
    logic [7:0] rv[6] = '{RST_CONN_LIMIT, RST_CARRIER_LIMIT, RST_TX_LIMIT, RST_TX_SPEED,
        RST_CHAR_LEN, RST_PARITY};
    logic [5:0] bi[4] = '{6'h2C, REG_PARITY, REG_PARITY, REG_PARITY};
    logic [7:0] bv[4] = '{8'h01, 8'h05, PAR_FORCE_ONE, PAR_FORCE_ZERO};
    logic [9:0] be[4] = '{ERR_BAD_REG, ERR_BAD_VALUE, ERR_BAD_FORMAT, ERR_BAD_FORMAT};
    logic [9:0] fe[4] = '{ERR_RX_OVERRUN, ERR_HOST_OVERFLOW, ERR_LOST_CARRIER, ERR_NO_CONNECT};
    always #50 clk = ~clk;
    des_supervisor #(.CYC_LIMIT_UNIT(10), .CYC_TX_UNIT(50)) des_supervisor_inst (.clk, .srst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .dsr, .dcd, .cts, .ext_tx_clk, .self_test_fail(stf),
        .serial_receiver_holding_buffer_overrun(ovr), .host_buffer_overflow(hovf),
        .tx_pending(1'b0), .tx_activity(1'b0), .rx_activity(1'b0), .line_enable,
        .ext_clk_select, .irq);
    des_line_model des_line_model_inst (.clk, .line_enable, .answer, .dsr, .dcd, .cts,
        .ext_tx_clk);
    // --------------------------------------------------------------
    // bus tasks and checks
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= {i, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) miscompares++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [5:0] i, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, i, 32'h0000_0000);
    endtask
    task automatic sig(input logic [1:0] e);
        repeat (2) @(posedge clk);
        checks_done++;
        if ({irq, ext_clk_select} !== e) begin
            miscompares++;
            $display("[FAIL] irq,ext_clk_select exp %b got %b", e, {irq, ext_clk_select});
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // x in an expected word means the value is left open
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
            checks_done++;
            if (!$isunknown(expq[0]) && avs_readdata !== expq[0]) begin
                miscompares++;
                $display("[FAIL] readdata exp %h got %h", expq[0], avs_readdata);
            end
            void'(expq.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(REG_ERR_CODE, 32'(ERR_SELF_TEST));
        stf <= 1'b0;
        foreach (ri[i]) rd(ri[i], 32'(rv[i]));
        lfsr = lfsr_next(lfsr);
        bus(1'b1, REG_TX_LIMIT, 32'(lfsr[6:0]));
        rd(REG_TX_LIMIT, 32'(lfsr[6:0]));
        bus(1'b1, REG_TX_SPEED, 32'h0000_0000);
        sig(2'b01);
        bus(1'b1, REG_TX_SPEED, 32'(RST_TX_SPEED));
        bus(1'b1, REG_CHAR_LEN, 32'(CHAR_LEN_8));
        rd(6'h01, 32'h0000_0000);
        rd(REG_ERR_CODE, 32'(ERR_BAD_REG));
        foreach (bi[i]) begin
            bus(1'b1, bi[i], 32'(bv[i]));
            rd(REG_ERR_CODE, 32'(be[i]));
        end
        rd(REG_PARITY, 32'(RST_PARITY));
        bus(1'b1, REG_IRQ_MASK, 32'h0000_0007);
        sig(2'b10);
        rd(REG_IRQ_STATUS, 32'h0000_0005);
        sig(2'b00);
        bus(1'b1, REG_CONN_LIMIT, 32'h0000_0001);
        bus(1'b1, REG_CARRIER_LIMIT, 32'h0000_0002);
        for (int k = 0; k < 4; k++) begin
            answer <= (k != 3);
            bus(1'b1, REG_CONNECT, 32'h0000_0001);
            repeat (20) @(posedge clk);
            if (k < 3) rd(REG_CONNECT, 32'(LINE_CONNECTED));
            ovr <= (k == 0);
            hovf <= (k == 1);
            answer <= (k < 2);
            @(posedge clk);
            ovr <= 1'b0;
            hovf <= 1'b0;
            repeat (120) @(posedge clk);
            rd(REG_CONNECT, 32'(LINE_SUSPENDED));
            rd(REG_ERR_CODE, 32'(fe[k]));
            sig(2'b10);
            bus(1'b1, REG_CONNECT, 32'h0000_0001);
            rd(REG_CONNECT, 32'(LINE_SUSPENDED));
            bus(1'b1, REG_CLEAR, 32'h0000_0001);
            rd(REG_CONNECT, 32'(LINE_IDLE));
            rd(REG_IRQ_STATUS, 32'h0000_0002);
        end
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule
